// ### hdl/lfs_pkg.sv
// constants and state types shared by the open_load_flag status register bank
package lfs_pkg;

   // =====================================================================
   // direct register addresses and reset values
   localparam logic [7:0] LFS_ADDR_STATUS   = 8'h02;
   localparam logic [7:0] LFS_ADDR_PRESC    = 8'h03;
   localparam logic [7:0] LFS_ADDR_CH_LOW   = 8'h04;
   localparam logic [7:0] LFS_RST_STATUS    = 8'h00;
   localparam logic [7:0] LFS_RST_PRESC     = 8'h00;
   localparam logic [7:0] LFS_RST_CH_LOW    = 8'h00;
   localparam logic [7:0] LFS_RD_UNMAPPED   = 8'h00;

   // =====================================================================
   // command codes that may reach each register
   localparam logic [7:0] LFS_CMD_RD_STATUS = 8'h08;
   localparam logic [7:0] LFS_CMD_RD_CHAN   = 8'h09;
   localparam logic [7:0] LFS_CMD_RD_ALL    = 8'h0a;
   localparam logic [7:0] LFS_CMD_WR_PRESC  = 8'h03;

   // =====================================================================
   // field positions
   localparam int unsigned LFS_BIT_REXT  = 7;
   localparam int unsigned LFS_BIT_MSG   = 6;
   localparam int unsigned LFS_BIT_GEN   = 5;
   localparam int unsigned LFS_BIT_DIAG  = 4;
   localparam int unsigned LFS_BIT_TALRT = 3;
   localparam int unsigned LFS_BIT_TFAIL = 2;
   localparam int unsigned LFS_BIT_EXT   = 1;
   localparam int unsigned LFS_BIT_OPEN  = 0;
   localparam int unsigned LFS_BIT_PRESC = 7;
   localparam int unsigned LFS_NUM_CH    = 12;
   localparam int unsigned LFS_UPPER_LSB = 8;

   // =====================================================================
   // persistence window, 10 us at a 10 ns clock, rounded up
   localparam int unsigned LFS_PERSIST_NS    = 10000;
   localparam int unsigned LFS_CLK_PERIOD_NS = 10;
   localparam int unsigned LFS_PERSIST_CYC   = (LFS_PERSIST_NS + LFS_CLK_PERIOD_NS - 1) / LFS_CLK_PERIOD_NS;
   localparam int unsigned LFS_CNT_W         = 10;

   // filter slots: channels first, then the three summary faults
   localparam int unsigned LFS_F_REXT = 12;
   localparam int unsigned LFS_F_EXT  = 13;
   localparam int unsigned LFS_F_OPEN = 14;
   localparam int unsigned LFS_NUM_F  = 15;

   typedef struct packed {
      logic                 flag;
      logic                 last_raw;
      logic [LFS_CNT_W-1:0] cnt;
   } lfs_filt_state_t;

   typedef struct packed {
      logic [7:0]            status;
      logic [LFS_NUM_CH-1:0] chan;
      logic                  presc;
      logic                  bus_driven_operation;
      logic                  rd_valid;
      logic [7:0]            rd_data;
   } lfs_top_state_t;

endpackage

// ### hdl/lfs_pf_if.sv
// carrier between the register bank and one persistence filter
`timescale 1ns/1ns
interface lfs_pf_if;
   logic ce;
   logic raw;
   logic hold;
   logic clr;
   logic flag;
   modport bank (output ce, output raw, output hold, output clr, input flag);
   modport filt (input ce, input raw, input hold, input clr, output flag);
endinterface

// ### hdl/lfs_pfilt.sv
// persistence filter: output follows the raw fault once it stays put for the window
`timescale 1ns/1ns
module lfs_pfilt #(
   parameter int unsigned PERSIST = lfs_pkg::LFS_PERSIST_CYC
) (
   input  wire logic   i_core_clk,
   input  wire logic   i_rstn,
   lfs_pf_if.filt      bus
);
   import lfs_pkg::*;

   localparam logic [LFS_CNT_W-1:0] CNT_LAST = LFS_CNT_W'(PERSIST - 1);

   lfs_filt_state_t st_r;
   lfs_filt_state_t st_nxt;

   // =====================================================================
   // next state: hold freezes, clear wipes, a raw change restarts the count
   always_comb begin
      st_nxt = st_r;
      if (bus.ce) begin
         if (bus.clr) begin
            st_nxt = '0;
         end else if (!bus.hold) begin
            if (bus.raw != st_r.last_raw) begin
               st_nxt.last_raw = bus.raw;
               st_nxt.cnt      = '0;
            end else if (st_r.flag != st_r.last_raw) begin
               if (st_r.cnt == CNT_LAST) begin
                  st_nxt.flag = st_r.last_raw;
                  st_nxt.cnt  = '0;
               end else begin
                  st_nxt.cnt = st_r.cnt + 1'b1;
               end
            end
         end
      end
   end

   // =====================================================================
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign bus.flag = st_r.flag;

   // the flag may only move when the full window has been counted, or on a clear
   property p_flag_after_window;
      @(posedge i_core_clk) disable iff (!i_rstn)
      ($changed(st_r.flag) && !$past(bus.clr)) |-> ($past(st_r.cnt) == CNT_LAST);
   endproperty
   a_p_flag_after_window: assert property (p_flag_after_window)
      else $error("filter flag moved before the persistence window ended");

endmodule

// ### hdl/lfs_bank.sv
// fault status and prescaler register bank of a 12-channel led driver
//
// Function
// - status register at 0x02, read only, reset 0x00, via commands 0x08 and 0x0a
// - bit 7 rext short, 10 us latch and release, cleared when dimming input off
// - in bus-driven operation rext short masks the external flag fault bit
// - bit 6 set on message error, cleared by reading the status register
// - bit 5 mirrors the all-outputs enable signal
// - bit 4 mirrors the supply diagnostic window above the power-good threshold
// - bit 3 set on temperature alert, cleared only by status read
// - bit 2 set over shutdown temperature, cleared by status read
// - bit 1 flag line fault, 10 us latch and 10 us release
// - bit 0 open load only while diag window, 10 us latch and release
// - open load bit held when supply drops below the power-good threshold
// - register 0x03 resets 0x00, bit 7 writable, bits 3..0 read only
// - register 0x03 reached by commands 0x09, 0x0a, 0x03; only bit 7 written
// - bit 7 of 0x03 selects 220 Hz when 0, 110 Hz when 1
// - bits 3..0 of 0x03 show channel 11..8 faults, set only internally
// - channel bits set only in diag window, 10 us latch, cleared on read
// - bits 6..4 unused; writes to bits 3..0 leave channel faults alone
// - register 0x04 holds channel 7..0 faults with same behaviour
`timescale 1ns/1ns
module lfs_bank (
   input  wire logic                          i_core_clk,
   input  wire logic                          i_rstn,
   input  wire logic                          i_ce,
   input  wire logic                          i_acc_valid,
   input  wire logic                          i_acc_write,
   input  wire logic [7:0]                    i_acc_cmd,
   input  wire logic [7:0]                    i_acc_addr,
   input  wire logic [7:0]                    i_acc_wdata,
   output logic                               o_rd_valid,
   output logic [7:0]                         o_rd_data,
   input  wire logic                          i_rext_short,
   input  wire logic                          i_flag_line_fault,
   input  wire logic                          i_open_load_flag,
   input  wire logic [lfs_pkg::LFS_NUM_CH-1:0] i_chan_fault,
   input  wire logic                          i_global_dimming_input,
   input  wire logic                          i_bus_driven_operation,
   input  wire logic                          i_msg_err,
   input  wire logic                          i_global_en,
   input  wire logic                          i_power_good,
   input  wire logic                          i_temp_alert,
   input  wire logic                          i_temp_shutdown,
   output logic [7:0]                         o_status,
   output logic [lfs_pkg::LFS_NUM_CH-1:0]     o_per_channel_fault_bits,
   output logic                               o_prescale_half
);
   import lfs_pkg::*;

   localparam logic [LFS_NUM_CH-1:0] UPPER_MASK = 12'hf00;
   localparam logic [LFS_NUM_CH-1:0] LOWER_MASK = 12'h0ff;

   lfs_top_state_t          st_r;
   lfs_top_state_t          st_nxt;
   logic [LFS_NUM_F-1:0]    filt;
   logic                    diag_now;
   logic                    rd_take;
   logic                    cmd_status;
   logic                    cmd_chan;
   logic                    rd_status;
   logic                    rd_presc;
   logic                    rd_ch_low;
   logic                    wr_presc;
   logic [LFS_NUM_CH-1:0]   ch_clr;
   logic [LFS_NUM_CH-1:0]   ch_set;

   // =====================================================================
   // access decode: the command code gates which register a direct address reaches
   assign rd_take    = i_acc_valid && !i_acc_write;
   assign cmd_status = (i_acc_cmd == LFS_CMD_RD_STATUS) || (i_acc_cmd == LFS_CMD_RD_ALL);
   assign cmd_chan   = (i_acc_cmd == LFS_CMD_RD_CHAN) || (i_acc_cmd == LFS_CMD_RD_ALL)
                       || (i_acc_cmd == LFS_CMD_WR_PRESC);
   assign rd_status  = i_ce && rd_take && (i_acc_addr == LFS_ADDR_STATUS) && cmd_status;
   assign rd_presc   = i_ce && rd_take && (i_acc_addr == LFS_ADDR_PRESC) && cmd_chan;
   assign rd_ch_low  = i_ce && rd_take && (i_acc_addr == LFS_ADDR_CH_LOW) && cmd_chan;
   assign wr_presc   = i_ce && i_acc_valid && i_acc_write && (i_acc_addr == LFS_ADDR_PRESC)
                       && cmd_chan;

   // channel bits are cleared per byte: only the register that was read loses its faults
   assign ch_clr   = (rd_presc ? UPPER_MASK : '0) | (rd_ch_low ? LOWER_MASK : '0);
   assign diag_now = st_r.status[LFS_BIT_DIAG];
   assign ch_set   = filt[LFS_NUM_CH-1:0] & {LFS_NUM_CH{diag_now}};

   // =====================================================================
   // one persistence filter per fault source; slots 0..11 channels, then rext, flag, open
   lfs_pf_if pf_bus [LFS_NUM_F] ();

   for (genvar g = 0; g < LFS_NUM_F; g++) begin : g_filt
      assign pf_bus[g].ce = i_ce;
      if (g < LFS_NUM_CH) begin : g_ch
         // channel detection only counts inside the diagnostic supply window
         assign pf_bus[g].raw  = i_chan_fault[g];
         assign pf_bus[g].hold = !diag_now;
         assign pf_bus[g].clr  = 1'b0;
      end else if (g == LFS_F_REXT) begin : g_rext
         // dimming input off wipes the rext fault at once, without waiting the window
         assign pf_bus[g].raw  = i_rext_short;
         assign pf_bus[g].hold = 1'b0;
         assign pf_bus[g].clr  = !i_global_dimming_input;
      end else if (g == LFS_F_EXT) begin : g_ext
         assign pf_bus[g].raw  = i_flag_line_fault;
         assign pf_bus[g].hold = 1'b0;
         assign pf_bus[g].clr  = 1'b0;
      end else begin : g_open
         // freezing rather than clearing keeps the open fault across a supply dip
         assign pf_bus[g].raw  = i_open_load_flag;
         assign pf_bus[g].hold = !diag_now;
         assign pf_bus[g].clr  = 1'b0;
      end
      assign filt[g] = pf_bus[g].flag;

      lfs_pfilt #(
         .PERSIST (LFS_PERSIST_CYC)
      ) u_filt (
         .i_core_clk (i_core_clk),
         .i_rstn     (i_rstn),
         .bus        (pf_bus[g])
      );
   end

   // =====================================================================
   // next state of the whole bank; nothing moves while the clock enable is low
   always_comb begin
      st_nxt = st_r;
      if (i_ce) begin
         st_nxt.bus_driven_operation      = i_bus_driven_operation;
         st_nxt.rd_valid = rd_take;
         // read data is taken from the present value, before any clear lands
         if (rd_status) begin
            st_nxt.rd_data = st_r.status;
         end else if (rd_presc) begin
            st_nxt.rd_data = {st_r.presc, 3'b000, st_r.chan[LFS_NUM_CH-1:LFS_UPPER_LSB]};
         end else if (rd_ch_low) begin
            st_nxt.rd_data = st_r.chan[LFS_UPPER_LSB-1:0];
         end else begin
            st_nxt.rd_data = LFS_RD_UNMAPPED;
         end

         // summary bits filtered by hardware, then the enable and diagnostic window mirrors
         st_nxt.status[LFS_BIT_REXT] = filt[LFS_F_REXT] && i_global_dimming_input;
         st_nxt.status[LFS_BIT_EXT]  = filt[LFS_F_EXT]
                                       && !(i_bus_driven_operation && st_nxt.status[LFS_BIT_REXT]);
         st_nxt.status[LFS_BIT_OPEN] = filt[LFS_F_OPEN];
         st_nxt.status[LFS_BIT_GEN]  = i_global_en;
         st_nxt.status[LFS_BIT_DIAG] = i_power_good;

         // sticky bits: set and clear in one cycle resolves to set
         st_nxt.status[LFS_BIT_MSG]   = (st_r.status[LFS_BIT_MSG] && !rd_status) || i_msg_err;
         st_nxt.status[LFS_BIT_TALRT] = (st_r.status[LFS_BIT_TALRT] && !rd_status) || i_temp_alert;
         st_nxt.status[LFS_BIT_TFAIL] = (st_r.status[LFS_BIT_TFAIL] && !rd_status)
                                        || i_temp_shutdown;
         st_nxt.chan = (st_r.chan & ~ch_clr) | ch_set;

         // only bit 7 of a write is kept; the channel field ignores host data
         if (wr_presc) begin
            st_nxt.presc = i_acc_wdata[LFS_BIT_PRESC];
         end
      end
   end

   // =====================================================================
   // state register
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_r.status   <= LFS_RST_STATUS;
         st_r.chan     <= {LFS_RST_PRESC[3:0], LFS_RST_CH_LOW};
         st_r.presc    <= LFS_RST_PRESC[LFS_BIT_PRESC];
         st_r.bus_driven_operation      <= 1'b0;
         st_r.rd_valid <= 1'b0;
         st_r.rd_data  <= LFS_RD_UNMAPPED;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state flops
   assign o_rd_valid               = st_r.rd_valid;
   assign o_rd_data                = st_r.rd_data;
   assign o_status                 = st_r.status;
   assign o_per_channel_fault_bits = st_r.chan;
   assign o_prescale_half          = st_r.presc;

   // =====================================================================
   // checks
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rstn);

   sequence s_status_read;
      rd_status;
   endsequence

   sequence s_status_read_no_msg;
      rd_status && !i_msg_err;
   endsequence

   property p_rd_answer;
      (i_ce && rd_take) |=> o_rd_valid;
   endproperty
   a_p_rd_answer: assert property (p_rd_answer)
      else $error("read answer pulse not produced one cycle after request");

   property p_rd_quiet;
      (i_ce && !rd_take) |=> !o_rd_valid;
   endproperty
   a_p_rd_quiet: assert property (p_rd_quiet)
      else $error("read answer pulse without a taken read");

   property p_status_capture;
      s_status_read |=> (o_rd_data == $past(o_status));
   endproperty
   a_p_status_capture: assert property (p_status_capture)
      else $error("status read did not return the value before the clear");

   property p_msg_clear;
      s_status_read_no_msg |=> !o_status[LFS_BIT_MSG];
   endproperty
   a_p_msg_clear: assert property (p_msg_clear)
      else $error("message error bit survived a status read");

   property p_msg_set_wins;
      (i_ce && i_msg_err) |=> o_status[LFS_BIT_MSG];
   endproperty
   a_p_msg_set_wins: assert property (p_msg_set_wins)
      else $error("message error lost");

   property p_alert_sticky;
      (o_status[LFS_BIT_TALRT] && !rd_status) |=> o_status[LFS_BIT_TALRT];
   endproperty
   a_p_alert_sticky: assert property (p_alert_sticky)
      else $error("temperature alert cleared without a status read");

   property p_fail_clear;
      (rd_status && !i_temp_shutdown) |=> !o_status[LFS_BIT_TFAIL];
   endproperty
   a_p_fail_clear: assert property (p_fail_clear)
      else $error("shutdown bit survived a status read");

   property p_mirrors;
      i_ce |=> (o_status[LFS_BIT_GEN] == $past(i_global_en))
               && (o_status[LFS_BIT_DIAG] == $past(i_power_good));
   endproperty
   a_p_mirrors: assert property (p_mirrors)
      else $error("enable or diagnostic window bit does not follow its input");

   property p_rext_off;
      (i_ce && !i_global_dimming_input) |=> !o_status[LFS_BIT_REXT] && !filt[LFS_F_REXT];
   endproperty
   a_p_rext_off: assert property (p_rext_off)
      else $error("rext fault not cleared by dimming input off");

   property p_ext_masked;
      (o_status[LFS_BIT_REXT] && st_r.bus_driven_operation) |-> !o_status[LFS_BIT_EXT];
   endproperty
   a_p_ext_masked: assert property (p_ext_masked)
      else $error("flag line fault reported alongside rext fault in bus-driven operation");

   property p_presc_write;
      wr_presc |=> (o_prescale_half == $past(i_acc_wdata[LFS_BIT_PRESC]))
                   && (o_per_channel_fault_bits == ($past(o_per_channel_fault_bits) | $past(ch_set)));
   endproperty
   a_p_presc_write: assert property (p_presc_write)
      else $error("prescaler write not applied or touched channel faults");

   property p_chan_set_in_window;
      (i_ce && $past(i_ce) && $rose(o_per_channel_fault_bits[0])) |-> $past(diag_now);
   endproperty
   a_p_chan_set_in_window: assert property (p_chan_set_in_window)
      else $error("channel fault set outside diagnostic window");

   property p_low_clear;
      (rd_ch_low && !(|ch_set[LFS_UPPER_LSB-1:0]))
         |=> (o_per_channel_fault_bits[LFS_UPPER_LSB-1:0] == '0) && (o_rd_data == $past(st_r.chan[7:0]));
   endproperty
   a_p_low_clear: assert property (p_low_clear)
      else $error("low channel register read did not capture then clear");

   property p_open_hold;
      (i_ce && !diag_now) |=> (filt[LFS_F_OPEN] == $past(filt[LFS_F_OPEN]));
   endproperty
   a_p_open_hold: assert property (p_open_hold)
      else $error("open load filter changed outside the diagnostic window");

   property p_ext_follow;
      (i_ce && !i_bus_driven_operation) |=> (o_status[LFS_BIT_EXT] == $past(filt[LFS_F_EXT]));
   endproperty
   a_p_ext_follow: assert property (p_ext_follow)
      else $error("flag line fault bit does not follow its filter");

   property p_open_follow;
      i_ce |=> (o_status[LFS_BIT_OPEN] == $past(filt[LFS_F_OPEN]));
   endproperty
   a_p_open_follow: assert property (p_open_follow)
      else $error("open load bit does not follow its filter");

   property p_chan_hold;
      (i_ce && !diag_now) |=> (filt[LFS_NUM_CH-1:0] == $past(filt[LFS_NUM_CH-1:0]));
   endproperty
   a_p_chan_hold: assert property (p_chan_hold)
      else $error("channel filters moved outside the diagnostic window");

   property p_upper_clear;
      (rd_presc && !(|ch_set[LFS_NUM_CH-1:LFS_UPPER_LSB]))
         |=> (o_per_channel_fault_bits[LFS_NUM_CH-1:LFS_UPPER_LSB] == '0);
   endproperty
   a_p_upper_clear: assert property (p_upper_clear)
      else $error("upper channel faults survived a read of their register");

   property p_chan_sticky;
      (o_per_channel_fault_bits[0] && !rd_ch_low) |=> o_per_channel_fault_bits[0];
   endproperty
   a_p_chan_sticky: assert property (p_chan_sticky)
      else $error("channel fault cleared without a read of its register");

   property p_unmapped;
      (i_ce && rd_take && !rd_status && !rd_presc && !rd_ch_low) |=> (o_rd_data == LFS_RD_UNMAPPED);
   endproperty
   a_p_unmapped: assert property (p_unmapped)
      else $error("refused or unmapped read returned data");

   property p_presc_keep;
      !wr_presc |=> $stable(o_prescale_half);
   endproperty
   a_p_presc_keep: assert property (p_presc_keep)
      else $error("prescaler select moved without an accepted write");

   property p_alert_set;
      (i_ce && i_temp_alert) |=> o_status[LFS_BIT_TALRT];
   endproperty
   a_p_alert_set: assert property (p_alert_set)
      else $error("temperature alert not recorded");

   property p_shut_set;
      (i_ce && i_temp_shutdown) |=> o_status[LFS_BIT_TFAIL];
   endproperty
   a_p_shut_set: assert property (p_shut_set)
      else $error("shutdown temperature not recorded");

   property p_fail_sticky;
      (o_status[LFS_BIT_TFAIL] && !rd_status) |=> o_status[LFS_BIT_TFAIL];
   endproperty
   a_p_fail_sticky: assert property (p_fail_sticky)
      else $error("shutdown bit cleared without a status read");

endmodule

// ### tb/lfs_host.sv
// host model issuing single-byte register accesses to the bank
`timescale 1ns/1ns
module lfs_host (
   input  wire logic       i_core_clk,
   input  wire logic       i_rd_valid,
   input  wire logic [7:0] i_rd_data,
   output logic            o_acc_valid,
   output logic            o_acc_write,
   output logic [7:0]      o_acc_cmd,
   output logic [7:0]      o_acc_addr,
   output logic [7:0]      o_acc_wdata
);
   initial begin
      o_acc_valid = 1'b0;
      o_acc_write = 1'b0;
      o_acc_cmd   = 8'h00;
      o_acc_addr  = 8'h00;
      o_acc_wdata = 8'h00;
   end
   // =====================================================================
   // one access: held up to the taking edge, then idle lines are scrambled
   // so a stale command can never pass for a live one
   task automatic access(input logic wr, input logic [7:0] cmd, addr, wd, output logic [7:0] rd, output logic ok);
      @(posedge i_core_clk);
      #1;
      o_acc_valid = 1'b1;
      o_acc_write = wr;
      o_acc_cmd   = cmd;
      o_acc_addr  = addr;
      o_acc_wdata = wd;
      @(posedge i_core_clk);
      #1;
      o_acc_valid = 1'b0;
      o_acc_cmd   = ~cmd;
      o_acc_addr  = ~addr;
      o_acc_wdata = ~wd;
      rd          = i_rd_data;
      ok          = i_rd_valid;
   endtask
endmodule

// ### tb/tb.sv
// self-checking bench for the open_load_flag status register bank
`timescale 1ns/1ns
module tb;
   import lfs_pkg::*;
   logic        clk, rstn, ce, rext, flg, opn, dim, bus_driven_operation, merr, gen, pg, talrt, tsd;
   logic [11:0] chf, chan;
   logic        av, aw, rv, half;
   logic [7:0]  ac, aa, ad, rdat, status;
   int          bad_count, compares, cycles;

   lfs_host lfs_host_inst (.i_core_clk(clk), .i_rd_valid(rv), .i_rd_data(rdat), .o_acc_valid(av),
      .o_acc_write(aw), .o_acc_cmd(ac), .o_acc_addr(aa), .o_acc_wdata(ad));
   lfs_bank lfs_bank_inst (.i_core_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_acc_valid(av),
      .i_acc_write(aw), .i_acc_cmd(ac), .i_acc_addr(aa), .i_acc_wdata(ad), .o_rd_valid(rv),
      .o_rd_data(rdat), .i_rext_short(rext), .i_flag_line_fault(flg), .i_open_load_flag(opn),
      .i_chan_fault(chf), .i_global_dimming_input(dim), .i_bus_driven_operation(bus_driven_operation),
      .i_msg_err(merr), .i_global_en(gen), .i_power_good(pg), .i_temp_alert(talrt),
      .i_temp_shutdown(tsd), .o_status(status), .o_per_channel_fault_bits(chan),
      .o_prescale_half(half));

   // =====================================================================
   // clock and hang guard; the ceiling is several times the expected run
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         final_report();
      end
   end

   task automatic final_report();
      $display("bad_count=%0d compares=%0d", bad_count, compares);
      if (bad_count == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // waits n edges and steps past them so launched updates have landed
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] cmd, addr, exp);
      logic [7:0] d;
      logic       v;
      lfs_host_inst.access(1'b0, cmd, addr, 8'h00, d, v);
      chk({7'h00, v, d}, {8'h01, exp});
   endtask
   // a write never produces a read answer
   task automatic wr(input logic [7:0] cmd, wd);
      logic [7:0] d;
      logic       v;
      lfs_host_inst.access(1'b1, cmd, LFS_ADDR_PRESC, wd, d, v);
      chk({15'h0000, v}, 16'h0000);
   endtask

   // =====================================================================
   // scenarios
   task automatic t_reset();
      chk({8'h00, status}, 16'h0000);
      chk({half, 3'h0, chan}, 16'h0000);
      rd(8'h08, 8'h02, 8'h00);
      rd(8'h09, 8'h03, 8'h00);
      rd(8'h0a, 8'h04, 8'h00);
      rd(8'h0a, 8'h7f, 8'h00);
   endtask
   task automatic t_mirror();
      gen = 1'b1;
      pg  = 1'b1;
      cyc(2);
      chk({8'h00, status}, 16'h0030);
      gen = 1'b0;
      cyc(2);
      chk({8'h00, status}, 16'h0010);
   endtask
   // events offered while the clock enable is low must leave no trace
   task automatic t_freeze();
      ce   = 1'b0;
      merr = 1'b1;
      gen  = 1'b1;
      cyc(3);
      chk({8'h00, status}, 16'h0010);
      {ce, merr, gen} = 3'b100;
      cyc(2);
      chk({8'h00, status}, 16'h0010);
   endtask
   task automatic t_sticky();
      {merr, talrt, tsd} = 3'b111;
      cyc(1);
      {merr, talrt, tsd} = 3'b000;
      cyc(1);
      chk({8'h00, status}, 16'h005c);
      rd(8'h09, 8'h02, 8'h00);
      chk({8'h00, status}, 16'h005c);
      rd(8'h08, 8'h02, 8'h5c);
      chk({8'h00, status}, 16'h0010);
      talrt = 1'b1;
      rd(8'h0a, 8'h02, 8'h18);
      chk({8'h00, status}, 16'h0018);
      talrt = 1'b0;
      rd(8'h0a, 8'h02, 8'h18);
      chk({8'h00, status}, 16'h0010);
   endtask
   task automatic t_presc();
      logic [7:0] cmds [3] = '{8'h03, 8'h09, 8'h0a};
      foreach (cmds[i]) begin
         wr(cmds[i], 8'hff);
         chk({15'h0000, half}, 16'h0001);
         chk({4'h0, chan}, 16'h0000);
         rd(cmds[i], LFS_ADDR_PRESC, 8'h80);
         wr(cmds[i], 8'h00);
         chk({15'h0000, half}, 16'h0000);
      end
      wr(8'h08, 8'hff);
      chk({15'h0000, half}, 16'h0000);
   endtask
   // the change is seen at the first edge; the bit lands 1001 edges later
   task automatic t_filt();
      {bus_driven_operation, rext, flg} = 3'b011;
      cyc(1001);
      chk({8'h00, status}, 16'h0010);
      cyc(1);
      chk({8'h00, status}, 16'h0092);
      bus_driven_operation = 1'b1;
      cyc(1);
      chk({8'h00, status}, 16'h0090);
      dim = 1'b0;
      cyc(2);
      chk({8'h00, status}, 16'h0012);
      {rext, flg} = 2'b00;
      dim = 1'b1;
      cyc(1001);
      chk({8'h00, status}, 16'h0012);
      cyc(1);
      chk({8'h00, status}, 16'h0010);
   endtask
   task automatic t_diag();
      opn = 1'b1;
      chf = 12'ha05;
      cyc(1003);
      chk({8'h00, status}, 16'h0011);
      chf = 12'h000;
      cyc(1003);
      chk({4'h0, chan}, 16'h0a05);
      rd(8'h09, 8'h03, 8'h0a);
      chk({4'h0, chan}, 16'h0005);
      rd(8'h0a, 8'h04, 8'h05);
      chk({4'h0, chan}, 16'h0000);
      pg  = 1'b0;
      chf = 12'h001;
      cyc(1005);
      chk({8'h00, status}, 16'h0001);
      chk({4'h0, chan}, 16'h0000);
   endtask

   // =====================================================================
   // reset for 10 cycles, then the scenarios in turn
   initial begin
      {rstn, rext, flg, opn, bus_driven_operation, merr, gen, pg, talrt, tsd} = 10'h000;
      {ce, dim} = 2'b11;
      chf = 12'h000;
      repeat (10) @(posedge clk);
      #1;
      rstn = 1'b1;
      t_reset();
      t_mirror();
      t_freeze();
      t_sticky();
      t_presc();
      t_filt();
      t_diag();
      final_report();
   end
endmodule
